// ### shared/fpe_pkg.sv
// fpe_pkg: constants for the flash protection-erase / id / status block.
// assumes a 40 MHz system clock; all command decode values live here.
package fpe_pkg;
   // apb register byte offsets
   localparam logic [7:0] OFS_SEC_EN     = 8'h00;
   localparam logic [7:0] OFS_RSVD_A     = 8'h04;
   localparam logic [7:0] OFS_FLCS       = 8'h20;
   localparam logic [7:0] OFS_RSVD_B     = 8'h24;
   localparam logic [7:0] OFS_RSVD_C     = 8'h28;
   // field positions and reset values
   localparam int         FLCS_RDY_BIT   = 0;
   localparam int         FLCS_PROT_LSB  = 16;
   localparam int         SEC_EN_BIT     = 0;
   localparam logic       SEC_EN_RST     = 1'b1;
   localparam int         PROT_GROUP     = 4;
   // command cycle address high bytes and data codes
   localparam logic [7:0] ADR_54         = 8'h54;
   localparam logic [7:0] ADR_AA         = 8'hAA;
   localparam logic [7:0] DAT_AA         = 8'hAA;
   localparam logic [7:0] DAT_55         = 8'h55;
   localparam logic [7:0] CMD_RESET      = 8'hF0;
   localparam logic [7:0] CMD_ID         = 8'h90;
   localparam logic [7:0] CMD_ERASE_PRE  = 8'h80;
   localparam logic [7:0] CMD_PROT_ERASE = 8'h60;
   localparam int         ID_SEL_LSB     = 14;
   localparam int         GRP_SEL_BIT    = 14;
   // erase timing: time in microseconds, cycles derived from the clock
   localparam int         CLK_KHZ        = 40000;
   localparam int         ARRAY_ERASE_US = 100;
   localparam int         PROT_ERASE_US  = 50;
   localparam int         ARRAY_ERASE_CYC = (ARRAY_ERASE_US * CLK_KHZ) / 1000;
   localparam int         PROT_ERASE_CYC  = (PROT_ERASE_US * CLK_KHZ) / 1000;
   localparam int         TMR_W          = 16;
endpackage

// ### shared/fpe_tmr_if.sv
// fpe_tmr_if: start/done handshake between the sequencer and its erase timer.
// assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface fpe_tmr_if;
   logic                       start;
   logic [fpe_pkg::TMR_W-1:0]  cycles;
   logic                       done;
   modport ctl (output start, output cycles, input done);
   modport tmr (input start, input cycles, output done);
endinterface
`default_nettype wire

// ### src/fpe_erase_timer.sv
// fpe_erase_timer: counts the length of one automatic erase phase.
// assumes start is a one-cycle pulse and is not re-issued while counting.
`timescale 1ns/1ps
`default_nettype none
module fpe_erase_timer (
   // clock and reset
   input  wire logic  i_sys_clk,
   input  wire logic  i_srst,
   // sequencer side
   fpe_tmr_if.tmr     tmr
);
   logic [fpe_pkg::TMR_W-1:0] cnt_ff;
   logic [fpe_pkg::TMR_W-1:0] nxt_cnt;
   logic                      done_ff;
   logic                      nxt_done;

   always_comb begin
      nxt_cnt  = cnt_ff;
      nxt_done = 1'b0;
      if (tmr.start) begin
         nxt_cnt = tmr.cycles;
      end else if (cnt_ff != '0) begin
         nxt_cnt = cnt_ff - 1'b1;
         // done lands in the cycle after the last counted one
         if (cnt_ff == fpe_pkg::TMR_W'(1)) begin
            nxt_done = 1'b1;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         cnt_ff  <= '0;
         done_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         done_ff <= nxt_done;
      end
   end

   assign tmr.done = done_ff;
endmodule
`default_nettype wire

// ### src/fpe_flash_seq.sv
// fpe_flash_seq: protection-bit erase, identification_read_cmd mode and flash status registers.
// assumes command writes come from on-chip logic on i_sys_clk (no sync needed)
// and that the array macro reports erase failure on i_op_fail.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fpe_flash_seq #(
   parameter int             NBLK         = 6,
   parameter logic [NBLK-1:0] PROT_RST    = '0,
   parameter int             ARRAY_CYC    = fpe_pkg::ARRAY_ERASE_CYC,
   parameter int             PROT_CYC     = fpe_pkg::PROT_ERASE_CYC
) (
   // clock and resets
   input  wire logic              i_sys_clk,
   input  wire logic              i_srst,
   input  wire logic              i_cold_srst,
   // apb slave
   input  wire logic              i_psel,
   input  wire logic              i_penable,
   input  wire logic              i_pwrite,
   input  wire logic [7:0]        i_paddr,
   input  wire logic [31:0]       i_pwdata,
   output logic [31:0]            o_prdata,
   output logic                   o_pready,
   output logic                   o_pslverr,
   // flash command write port
   input  wire logic              i_cmd_wr,
   input  wire logic [15:0]       i_cmd_addr,
   input  wire logic [7:0]        i_cmd_data,
   // flash array side
   input  wire logic              i_op_fail,
   output logic                   o_array_erase,
   output logic                   o_id_mode,
   output logic [1:0]             o_id_sel,
   output logic [NBLK-1:0]        o_block_protect_flags,
   output logic                   o_ready_busy_flag
);
   typedef enum logic [3:0] {
      S_IDLE, S_C2, S_C3, S_ID4, S_ID, S_P4, S_P5, S_P6, S_P7,
      S_ARRAY, S_PROT, S_PPART, S_LOCK
   } fpe_state_e;

   localparam int NGRP = (NBLK + fpe_pkg::PROT_GROUP - 1) / fpe_pkg::PROT_GROUP;

   fpe_state_e          state_ff, nxt_state;
   logic                id_mode_ff, nxt_id_mode;
   logic [1:0]          id_sel_ff, nxt_id_sel;
   logic [NBLK-1:0]     prot_ff, nxt_prot;
   logic [NBLK-1:0]     grp_mask_ff, nxt_grp_mask;
   logic                busy_ff, nxt_busy;
   logic                sec_en_ff, nxt_sec_en;
   logic [31:0]         prdata_ff, nxt_prdata;
   logic                pready_ff, nxt_pready;
   logic                pslverr_ff, nxt_pslverr;
   logic                erase_ff, nxt_erase;
   logic                wr_54, wr_aa, apb_wr;
   logic [NBLK-1:0]     grp_sel [NGRP];
   logic [31:0]         flcs_val;

   fpe_tmr_if tmr_if ();

   fpe_erase_timer u_tmr (
      .i_sys_clk (i_sys_clk),
      .i_srst    (i_srst),
      .tmr       (tmr_if.tmr)
   );

   // one mask per group of four flags
   for (genvar g = 0; g < NGRP; g++) begin : g_grp
      for (genvar b = 0; b < NBLK; b++) begin : g_bit
         assign grp_sel[g][b] = (b / fpe_pkg::PROT_GROUP) == g;
      end
   end

   assign wr_54 = i_cmd_wr && i_cmd_addr[15:8] == fpe_pkg::ADR_54;
   assign wr_aa = i_cmd_wr && i_cmd_addr[15:8] == fpe_pkg::ADR_AA;

   always_comb begin
      nxt_state      = state_ff;
      nxt_id_mode    = id_mode_ff;
      nxt_id_sel     = id_sel_ff;
      nxt_prot       = prot_ff;
      nxt_grp_mask   = grp_mask_ff;
      nxt_busy       = busy_ff;
      nxt_erase      = erase_ff;
      tmr_if.start   = 1'b0;
      tmr_if.cycles  = '0;
      case (state_ff)
         S_IDLE: begin
            if (i_cmd_wr && i_cmd_data == fpe_pkg::CMD_RESET) begin
               nxt_id_mode = 1'b0;
            end else if (wr_54 && i_cmd_data == fpe_pkg::DAT_AA) begin
               nxt_state = S_C2;
            end
         end
         S_C2: begin
            if (i_cmd_wr) begin
               nxt_state = (wr_aa && i_cmd_data == fpe_pkg::DAT_55) ? S_C3 : S_IDLE;
            end
         end
         S_C3: begin
            if (i_cmd_wr) begin
               nxt_state = S_IDLE;
               if (wr_54 && i_cmd_data == fpe_pkg::CMD_RESET) begin
                  nxt_id_mode = 1'b0;
               end else if (wr_54 && i_cmd_data == fpe_pkg::CMD_ID) begin
                  nxt_state = S_ID4;
               end else if (wr_54 && i_cmd_data == fpe_pkg::CMD_ERASE_PRE) begin
                  nxt_state = S_P4;
               end
            end
         end
         S_ID4, S_ID: begin
            if (i_cmd_wr && i_cmd_data == fpe_pkg::CMD_RESET) begin
               nxt_id_mode = 1'b0;
               nxt_state   = S_IDLE;
            end else if (state_ff == S_ID && wr_54 && i_cmd_data == fpe_pkg::DAT_AA) begin
               nxt_state = S_C2;
            end else if (i_cmd_wr) begin
               nxt_id_mode = 1'b1;
               nxt_id_sel  = i_cmd_addr[fpe_pkg::ID_SEL_LSB +: 2];
               nxt_state   = S_ID;
            end
         end
         S_P4: begin
            if (i_cmd_wr) begin
               nxt_state = (wr_54 && i_cmd_data == fpe_pkg::DAT_AA) ? S_P5 : S_IDLE;
            end
         end
         S_P5: begin
            if (i_cmd_wr) begin
               nxt_state = (wr_aa && i_cmd_data == fpe_pkg::DAT_55) ? S_P6 : S_IDLE;
            end
         end
         S_P6: begin
            if (i_cmd_wr) begin
               nxt_state = (wr_54 && i_cmd_data == fpe_pkg::CMD_PROT_ERASE) ? S_P7 : S_IDLE;
            end
         end
         S_P7: begin
            if (i_cmd_wr) begin
               nxt_state = S_IDLE;
               if (i_cmd_data == fpe_pkg::CMD_PROT_ERASE) begin
                  nxt_busy = 1'b0;
                  if (sec_en_ff && (&prot_ff)) begin
                     nxt_state     = S_ARRAY;
                     nxt_erase     = 1'b1;
                     tmr_if.start  = 1'b1;
                     tmr_if.cycles = fpe_pkg::TMR_W'(ARRAY_CYC);
                  end else begin
                     nxt_state     = S_PPART;
                     nxt_grp_mask  = grp_sel[NGRP > 1 ?
                                     32'(i_cmd_addr[fpe_pkg::GRP_SEL_BIT]) % NGRP : 0];
                     tmr_if.start  = 1'b1;
                     tmr_if.cycles = fpe_pkg::TMR_W'(PROT_CYC);
                  end
               end
            end
         end
         S_ARRAY: begin
            if (i_op_fail) begin
               nxt_state = S_LOCK;
               nxt_erase = 1'b0;
            end else if (tmr_if.done) begin
               nxt_state     = S_PROT;
               nxt_erase     = 1'b0;
               tmr_if.start  = 1'b1;
               tmr_if.cycles = fpe_pkg::TMR_W'(PROT_CYC);
            end
         end
         S_PROT, S_PPART: begin
            if (i_op_fail) begin
               nxt_state = S_LOCK;
            end else if (tmr_if.done) begin
               nxt_prot    = (state_ff == S_PROT) ? '0 : (prot_ff & ~grp_mask_ff);
               nxt_busy    = 1'b1;
               nxt_id_mode = 1'b0;
               nxt_state   = S_IDLE;
            end
         end
         S_LOCK: begin
            nxt_busy = 1'b0;
         end
         default: begin
            nxt_state = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         state_ff    <= S_IDLE;
         id_mode_ff  <= 1'b0;
         id_sel_ff   <= '0;
         prot_ff     <= PROT_RST;
         grp_mask_ff <= '0;
         busy_ff     <= 1'b1;
         erase_ff    <= 1'b0;
      end else begin
         state_ff    <= nxt_state;
         id_mode_ff  <= nxt_id_mode;
         id_sel_ff   <= nxt_id_sel;
         prot_ff     <= nxt_prot;
         grp_mask_ff <= nxt_grp_mask;
         busy_ff     <= nxt_busy;
         erase_ff    <= nxt_erase;
      end
   end

   always_comb begin
      flcs_val = '0;
      flcs_val[fpe_pkg::FLCS_RDY_BIT] = busy_ff;
      flcs_val[fpe_pkg::FLCS_PROT_LSB +: NBLK] = prot_ff;
   end

   // data set up during the setup phase, so access completes with no wait
   assign apb_wr = i_psel && i_penable && i_pwrite && pready_ff;

   always_comb begin
      nxt_pready  = i_psel && !i_penable;
      nxt_pslverr = 1'b0;
      nxt_prdata  = '0;
      nxt_sec_en  = sec_en_ff;
      if (i_psel && !i_penable) begin
         case (i_paddr)
            fpe_pkg::OFS_SEC_EN: begin
               nxt_prdata[fpe_pkg::SEC_EN_BIT] = sec_en_ff;
            end
            fpe_pkg::OFS_FLCS: begin
               nxt_prdata = flcs_val;
            end
            default: begin
               nxt_pslverr = 1'b1;
            end
         endcase
      end
      if (apb_wr && i_paddr == fpe_pkg::OFS_SEC_EN) begin
         nxt_sec_en = i_pwdata[fpe_pkg::SEC_EN_BIT];
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         prdata_ff  <= '0;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         prdata_ff  <= nxt_prdata;
         pready_ff  <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   // cold reset only; hardware reset keeps the setting
   always_ff @(posedge i_sys_clk) begin
      if (i_cold_srst) begin
         sec_en_ff <= fpe_pkg::SEC_EN_RST;
      end else begin
         sec_en_ff <= nxt_sec_en;
      end
   end

   assign o_prdata              = prdata_ff;
   assign o_pready              = pready_ff;
   assign o_pslverr             = pslverr_ff;
   assign o_array_erase         = erase_ff;
   assign o_id_mode             = id_mode_ff;
   assign o_id_sel              = id_sel_ff;
   assign o_block_protect_flags = prot_ff;
   assign o_ready_busy_flag     = busy_ff;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);

   chk_busy_at_seventh: assert property (
      state_ff == S_P7 && i_cmd_wr && i_cmd_data == fpe_pkg::CMD_PROT_ERASE
      |=> !busy_ff ##1 !busy_ff)
      else $error("busy not low after seventh write");
   chk_array_first: assert property (
      state_ff == S_ARRAY && tmr_if.done && !i_op_fail
      |=> state_ff == S_PROT && !erase_ff && prot_ff == $past(prot_ff))
      else $error("array erase not followed by protection erase");
   chk_full_result: assert property (
      state_ff == S_PROT && tmr_if.done && !i_op_fail |=> flcs_val == 32'h0000_0001)
      else $error("status not one after full erase");
   chk_partial_clear: assert property (
      state_ff == S_PPART && tmr_if.done && !i_op_fail
      |=> prot_ff == ($past(prot_ff) & ~$past(grp_mask_ff)) && busy_ff)
      else $error("partial erase cleared wrong flags");
   chk_ignore_busy: assert property (
      (state_ff == S_ARRAY || state_ff == S_PROT || state_ff == S_PPART)
      && !tmr_if.done && !i_op_fail
      |=> state_ff == $past(state_ff) && !busy_ff)
      else $error("command accepted during erase");
   chk_return_read: assert property (
      state_ff == S_PPART && tmr_if.done && !i_op_fail |=> state_ff == S_IDLE && !id_mode_ff)
      else $error("no return to read mode");
   chk_lock_holds: assert property (
      state_ff == S_LOCK |=> state_ff == S_LOCK && !busy_ff)
      else $error("lock left without reset");
   chk_id_entry: assert property (
      state_ff == S_ID4 && i_cmd_wr && i_cmd_data != fpe_pkg::CMD_RESET
      |=> id_mode_ff && id_sel_ff == $past(i_cmd_addr[15:14]))
      else $error("id mode not entered on fourth write");
   chk_id_stays: assert property (
      id_mode_ff && !(i_cmd_wr && i_cmd_data == fpe_pkg::CMD_RESET)
      && !(state_ff == S_PPART || state_ff == S_PROT) |=> id_mode_ff)
      else $error("id mode left without read reset");
   chk_apb_ready: assert property (
      i_psel && !i_penable |=> pready_ff ##1 !pready_ff)
      else $error("apb ready timing wrong");
endmodule
`default_nettype wire

// ### testbench/fpe_cpu_model.sv
// fpe_cpu_model: on-chip cpu issuing flash command bus writes.
// assumes the sequencer takes one write per cycle of i_cmd_wr on i_sys_clk.
`timescale 1ns/1ps
`default_nettype none
module fpe_cpu_model (
   // clock
   input  wire logic        i_sys_clk,
   // command port
   output logic             o_cmd_wr,
   output logic [15:0]      o_cmd_addr,
   output logic [7:0]       o_cmd_data
);
   initial begin
      o_cmd_wr = 1'b0;
      o_cmd_addr = 16'h0000;
      o_cmd_data = 8'h00;
   end

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      o_cmd_wr <= 1'b1;
      o_cmd_addr <= {a[15:2], 2'b00};
      o_cmd_data <= d;
      @(posedge i_sys_clk);
      o_cmd_wr <= 1'b0;
      // released lines never keep the last value
      o_cmd_addr <= ~{a[15:2], 2'b00};
      o_cmd_data <= ~d;
   endtask

   task automatic seq(input logic [7:0] cmd);
      wr({fpe_pkg::ADR_54, 8'h00}, fpe_pkg::DAT_AA);
      wr({fpe_pkg::ADR_AA, 8'h00}, fpe_pkg::DAT_55);
      wr({fpe_pkg::ADR_54, 8'h00}, cmd);
   endtask

   task automatic prot_erase(input logic grp);
      seq(fpe_pkg::CMD_ERASE_PRE);
      wr({fpe_pkg::ADR_54, 8'h00}, fpe_pkg::DAT_AA);
      wr({fpe_pkg::ADR_AA, 8'h00}, fpe_pkg::DAT_55);
      wr({fpe_pkg::ADR_54, 8'h00}, fpe_pkg::CMD_PROT_ERASE);
      wr({1'b0, grp, 14'h0000}, fpe_pkg::CMD_PROT_ERASE);
   endtask

   // selector in bits 15:14, data zero
   task automatic id_pick(input logic [1:0] sel);
      wr({sel, 14'h0000}, 8'h00);
   endtask
endmodule
`default_nettype wire

// ### testbench/fpe_flash_seq_tb_top.sv
// fpe_flash_seq_tb_top: self-checking bench for the flash sequencer.
// assumes default erase counts and all protect flags set at reset.
`timescale 1ns/1ps
`default_nettype none
module fpe_flash_seq_tb_top;
   logic        i_sys_clk, i_srst, i_cold_srst, i_psel, i_penable, i_pwrite, i_op_fail;
   logic [7:0]  i_paddr;
   logic [31:0] i_pwdata, o_prdata, rd;
   logic        o_pready, o_pslverr, cmd_wr, o_array_erase, o_id_mode, o_ready_busy_flag;
   logic [15:0] cmd_addr;
   logic [7:0]  cmd_data;
   logic [1:0]  o_id_sel;
   logic [5:0]  flags;
   logic        werr;
   int          failures, comparisons, cycles;

   fpe_flash_seq #(.PROT_RST(6'h3F)) dut (
      .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_cold_srst(i_cold_srst),
      .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
      .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
      .o_pslverr(o_pslverr), .i_cmd_wr(cmd_wr), .i_cmd_addr(cmd_addr),
      .i_cmd_data(cmd_data), .i_op_fail(i_op_fail), .o_array_erase(o_array_erase),
      .o_id_mode(o_id_mode), .o_id_sel(o_id_sel), .o_block_protect_flags(flags),
      .o_ready_busy_flag(o_ready_busy_flag));
   fpe_cpu_model cpu (.i_sys_clk(i_sys_clk), .o_cmd_wr(cmd_wr), .o_cmd_addr(cmd_addr),
      .o_cmd_data(cmd_data));

   initial begin
      i_sys_clk = 1'b0;
      forever #12.5 i_sys_clk = ~i_sys_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   always @(posedge i_sys_clk) begin
      cycles++;
      // two partial erases and one full erase at default length, with margin
      if (cycles == 20000) begin
         failures++;
         conclude();
      end
   end

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic err);
      @(posedge i_sys_clk);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_sys_clk);
      i_penable <= 1'b1;
      do @(posedge i_sys_clk); while (o_pready !== 1'b1);
      r = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask

   task automatic reset_hw(input logic cold);
      @(posedge i_sys_clk);
      i_srst <= 1'b1;
      i_cold_srst <= cold;
      repeat (16) @(posedge i_sys_clk);
      i_srst <= 1'b0;
      i_cold_srst <= 1'b0;
   endtask

   // waits for ready, noting whether the array phase showed up
   task automatic wait_ready(output logic saw_array);
      saw_array = 1'b0;
      for (int n = 0; n < 8000 && o_ready_busy_flag !== 1'b1; n++) begin
         @(posedge i_sys_clk);
         #1;
         if (o_array_erase === 1'b1) saw_array = 1'b1;
      end
      check(o_ready_busy_flag, 1, "ready after erase");
   endtask

   task automatic t_regs();
      logic e;
      apb(0, fpe_pkg::OFS_SEC_EN, 0, rd, e);
      check(rd, 32'h0000_0001, "security enable reset");
      apb(1, fpe_pkg::OFS_FLCS, 32'hFFFF_FFFE, rd, e);
      apb(0, fpe_pkg::OFS_FLCS, 0, rd, e);
      check(rd, 32'h003F_0001, "status after write");
      for (int i = 0; i < 3; i++) begin
         apb(0, i == 0 ? fpe_pkg::OFS_RSVD_A :
                (i == 1 ? fpe_pkg::OFS_RSVD_B : fpe_pkg::OFS_RSVD_C), 0, rd, e);
         check({31'h0, e}, 1, "reserved refused");
      end
      apb(1, fpe_pkg::OFS_SEC_EN, 32'h0000_0000, rd, e);
      apb(0, fpe_pkg::OFS_SEC_EN, 0, rd, e);
      check(rd, 0, "security enable cleared");
   endtask

   task automatic t_partial(input logic grp, input logic [5:0] pre_flags,
                            input logic [5:0] exp_flags);
      logic s, e;
      apb(0, fpe_pkg::OFS_FLCS, 0, rd, e);
      check(rd[21:16], pre_flags, "flags before partial erase");
      cpu.prot_erase(grp);
      #1;
      check(o_ready_busy_flag, 0, "busy on seventh write");
      cpu.seq(fpe_pkg::CMD_ID);
      cpu.id_pick(2'b01);
      #1;
      check(o_id_mode, 0, "no id mode from busy sequence");
      wait_ready(s);
      check(s, 0, "no array erase");
      apb(0, fpe_pkg::OFS_FLCS, 0, rd, e);
      check(rd, {10'h000, exp_flags, 16'h0001}, "partial flags");
   endtask

   task automatic t_full();
      logic s, e;
      reset_hw(0);
      apb(0, fpe_pkg::OFS_FLCS, 0, rd, e);
      check(rd[21:16], 6'h3F, "flags before full erase");
      cpu.prot_erase(1'b0);
      // let the seventh write land before polling ready
      #1;
      wait_ready(s);
      check(s, 1, "array erase phase");
      apb(0, fpe_pkg::OFS_FLCS, 0, rd, e);
      check(rd, 32'h0000_0001, "status after full erase");
   endtask

   task automatic t_id();
      cpu.seq(fpe_pkg::CMD_ID);
      for (int k = 0; k < 4; k++) begin
         cpu.id_pick(k[1:0]);
         #1;
         check({o_id_mode, o_id_sel}, {1'b1, k[1:0]}, "id select");
      end
      cpu.seq(fpe_pkg::CMD_RESET);
      #1;
      check(o_id_mode, 0, "id left by read reset");
      cpu.seq(fpe_pkg::CMD_ID);
      cpu.id_pick(2'b10);
      cpu.wr({fpe_pkg::ADR_54, 8'h00}, fpe_pkg::CMD_RESET);
      #1;
      check(o_id_mode, 0, "id left by single reset write");
   endtask

   task automatic t_fail();
      logic e;
      reset_hw(0);
      apb(1, fpe_pkg::OFS_SEC_EN, 0, rd, e);
      i_op_fail <= 1'b1;
      cpu.prot_erase(1'b1);
      repeat (30) @(posedge i_sys_clk);
      #1;
      check(o_ready_busy_flag, 0, "locked after failure");
      i_op_fail <= 1'b0;
      reset_hw(0);
      #1;
      check({o_ready_busy_flag, flags}, 7'h7F, "ready after reset");
      apb(0, fpe_pkg::OFS_SEC_EN, 0, rd, e);
      check(rd, 0, "hardware reset keeps security enable");
      reset_hw(1);
      apb(0, fpe_pkg::OFS_SEC_EN, 0, rd, e);
      check(rd, 32'h0000_0001, "cold reset sets security enable");
   endtask

   initial begin
      failures = 0;
      comparisons = 0;
      cycles = 0;
      {i_srst, i_cold_srst, i_psel, i_penable, i_pwrite, i_op_fail} = 6'h30;
      i_paddr = 8'h00;
      i_pwdata = 32'h0000_0000;
      repeat (16) @(posedge i_sys_clk);
      i_srst <= 1'b0;
      i_cold_srst <= 1'b0;
      t_regs();
      t_partial(1'b0, 6'h3F, 6'h30);
      apb(1, fpe_pkg::OFS_SEC_EN, 32'h0000_0001, rd, werr);
      t_partial(1'b1, 6'h30, 6'h00);
      t_full();
      t_id();
      t_fail();
      conclude();
   end
endmodule
`default_nettype wire
